// [hw/alr_result_regs.sv]
/*
  Read-only result registers for two phototransistor channels.
  Assumes the converter offers a valid-qualified 13-bit count per channel, and
  that the serial slave issues one-cycle read or write strobes with an address.
*/
`timescale 1ns/1ps
// How it works
// R1: First channel bits 12:8 sit in upper byte bits 4:0; bits 7:5 read zero.
// R2: While a channel is enabled its result refreshes once every 80 ms.
// R3: Result bytes are read-only; host writes change nothing.
// R4: Host builds the count as upper times 0x100 plus lower.
// R5: Reported counts are clamped so they never exceed 8000.
// R6: Second channel bits 7:0 read at address 0x42.
// R7: Second channel bits 12:8 read in bits 4:0 at address 0x43.
// R8: First channel bits 7:0 read at address 0x40.
// R9: Lower and upper bytes of a read come from one measurement.
module alr_result_regs #(
  parameter int unsigned REFRESH_CYCLES = alr_pkg::REFRESH_CYC
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [1:0]        sensor_en,
  input  wire alr_pkg::alr_conv_s conv_first,
  input  wire alr_pkg::alr_conv_s conv_second,
  input  wire logic [7:0]        reg_addr,
  input  wire logic              reg_rd,
  input  wire logic              reg_wr,
  output logic [7:0]             reg_rdata,
  output logic                   reg_rvalid
);
  import alr_pkg::*;

  function automatic logic [12:0] clamp_count(input logic [12:0] c);
    return (c > COUNT_MAX) ? COUNT_MAX : c;
  endfunction : clamp_count

  logic [31:0]       tick_cnt_reg;
  logic              tick;
  logic [12:0]       latest_reg [2];
  logic [12:0]       result_reg [2];
  logic [4:0]        upper_shadow_reg [2];
  logic [12:0]       conv_in [2];
  logic [1:0]        conv_valid;
  logic              rd_take;

  assign conv_in[0]    = conv_first.count;
  assign conv_in[1]    = conv_second.count;
  assign conv_valid    = {conv_second.valid, conv_first.valid};
  assign tick          = (tick_cnt_reg == REFRESH_CYCLES - 1);
  // A write strobe never turns into a read and cancels a read in the same cycle; writes change no register
  assign rd_take       = reg_rd && !reg_wr;

  // Free-running refresh timer
  always_ff @(posedge clk) begin
    if (rst || tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'd1;
    end
  end

  // Hold the converter's newest count between refresh ticks
  always_ff @(posedge clk) begin
    for (int i = 0; i < 2; i++) begin
      if (rst) begin
        latest_reg[i] <= COUNT_RESET;
      end else if (conv_valid[i]) begin
        latest_reg[i] <= conv_in[i];
      end
    end
  end

  // Whole 13-bit result moves at once on the tick; no write path exists
  always_ff @(posedge clk) begin
    for (int i = 0; i < 2; i++) begin
      if (rst) begin
        result_reg[i] <= COUNT_RESET;
      end else if (tick && sensor_en[i]) begin
        result_reg[i] <= clamp_count(latest_reg[i]); // R2 R5 R3
      end
    end
  end

  // Reading a lower byte freezes its upper part, so a tick between the two
  // reads cannot mix conversions. Reading upper alone gives the last frozen value.
  always_ff @(posedge clk) begin
    for (int i = 0; i < 2; i++) begin
      if (rst) begin
        upper_shadow_reg[i] <= '0;
      end else if (rd_take && reg_addr == (i == 0 ? ADDR_FIRST_LOW : ADDR_SECOND_LOW)) begin
        upper_shadow_reg[i] <= result_reg[i][12:8]; // R9
      end
    end
  end

  // Read port; unmapped addresses read as zero
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata  <= RDATA_RESET;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= rd_take;
      if (rd_take) begin
        unique case (reg_addr)
          ADDR_FIRST_LOW:   reg_rdata <= result_reg[0][7:0];               // R8
          ADDR_FIRST_HIGH:  reg_rdata <= {3'b000, upper_shadow_reg[0]};    // R1
          ADDR_SECOND_LOW:  reg_rdata <= result_reg[1][7:0];               // R6
          ADDR_SECOND_HIGH: reg_rdata <= {3'b000, upper_shadow_reg[1]};    // R7
          default:          reg_rdata <= RDATA_RESET;
        endcase
      end
    end
  end

  property p_r1;
    @(posedge clk) disable iff (rst)
      rd_take && reg_addr == ADDR_FIRST_HIGH |=> reg_rdata[7:5] == 3'b000 && reg_rvalid;
  endproperty
  a_r1: assert property (p_r1) else $error("upper byte reserved bits not zero"); // R1

  property p_r2;
    @(posedge clk) disable iff (rst)
      tick && sensor_en[0] |=> result_reg[0] == clamp_count($past(latest_reg[0]));
  endproperty
  a_r2: assert property (p_r2) else $error("first result not refreshed on tick"); // R2

  property p_r2_hold;
    @(posedge clk) disable iff (rst)
      !tick || !sensor_en[1] |=> $stable(result_reg[1]);
  endproperty
  a_r2_hold: assert property (p_r2_hold) else $error("second result moved off tick"); // R2

  property p_r3;
    @(posedge clk) disable iff (rst)
      reg_wr && !tick |=> $stable(result_reg[0]) && $stable(result_reg[1]) && !reg_rvalid;
  endproperty
  a_r3: assert property (p_r3) else $error("write changed results"); // R3

  property p_r5;
    @(posedge clk) disable iff (rst)
      result_reg[0] <= COUNT_MAX && result_reg[1] <= COUNT_MAX;
  endproperty
  a_r5: assert property (p_r5) else $error("count above limit"); // R5

  property p_r6;
    @(posedge clk) disable iff (rst)
      rd_take && reg_addr == ADDR_SECOND_LOW |=> reg_rdata == $past(result_reg[1][7:0]);
  endproperty
  a_r6: assert property (p_r6) else $error("second lower byte wrong"); // R6

  property p_r7;
    @(posedge clk) disable iff (rst)
      rd_take && reg_addr == ADDR_SECOND_HIGH
        |=> reg_rdata == {3'b000, $past(upper_shadow_reg[1])};
  endproperty
  a_r7: assert property (p_r7) else $error("second upper byte wrong"); // R7

  property p_r8;
    @(posedge clk) disable iff (rst)
      rd_take && reg_addr == ADDR_FIRST_LOW |=> reg_rdata == $past(result_reg[0][7:0]);
  endproperty
  a_r8: assert property (p_r8) else $error("first lower byte wrong"); // R8

  sequence s_low_read0;
    rd_take && reg_addr == ADDR_FIRST_LOW;
  endsequence
  sequence s_high_read0;
    rd_take && reg_addr == ADDR_FIRST_HIGH;
  endsequence
  property p_r9;
    logic [12:0] snap;
    @(posedge clk) disable iff (rst)
      (s_low_read0, snap = result_reg[0]) ##1 s_high_read0
        |=> reg_rdata == {3'b000, snap[12:8]};
  endproperty
  a_r9: assert property (p_r9) else $error("upper byte from other conversion"); // R9

  sequence s_low_read1;
    rd_take && reg_addr == ADDR_SECOND_LOW;
  endsequence
  sequence s_high_read1;
    rd_take && reg_addr == ADDR_SECOND_HIGH;
  endsequence
  property p_r9_second;
    logic [12:0] snap;
    @(posedge clk) disable iff (rst)
      (s_low_read1, snap = result_reg[1]) ##1 s_high_read1
        |=> reg_rdata == {3'b000, snap[12:8]};
  endproperty
  a_r9_second: assert property (p_r9_second) else $error("second upper byte mixed"); // R9

  property p_r1_upper;
    @(posedge clk) disable iff (rst)
      rd_take && reg_addr == ADDR_FIRST_HIGH
        |=> reg_rdata == {3'b000, $past(upper_shadow_reg[0])};
  endproperty
  a_r1_upper: assert property (p_r1_upper) else $error("first upper byte wrong"); // R1

  property p_r2_second;
    @(posedge clk) disable iff (rst)
      tick && sensor_en[1] |=> result_reg[1] == clamp_count($past(latest_reg[1]));
  endproperty
  a_r2_second: assert property (p_r2_second) else $error("second result not refreshed"); // R2

  // Only an enabled tick may move a result, so reads between ticks agree
  property p_r2_hold_first;
    @(posedge clk) disable iff (rst)
      !(tick && sensor_en[0]) |=> $stable(result_reg[0]);
  endproperty
  a_r2_hold_first: assert property (p_r2_hold_first) else $error("first result moved"); // R2

  property p_r2_timer;
    @(posedge clk) disable iff (rst)
      tick_cnt_reg < REFRESH_CYCLES;
  endproperty
  a_r2_timer: assert property (p_r2_timer) else $error("refresh timer overran"); // R2

  property p_r3_shadow;
    @(posedge clk) disable iff (rst)
      reg_wr |=> $stable(upper_shadow_reg[0]) && $stable(upper_shadow_reg[1]);
  endproperty
  a_r3_shadow: assert property (p_r3_shadow) else $error("write moved upper shadow"); // R3

  property p_r5_clamp;
    @(posedge clk) disable iff (rst)
      tick && sensor_en[0] && latest_reg[0] > COUNT_MAX |=> result_reg[0] == COUNT_MAX;
  endproperty
  a_r5_clamp: assert property (p_r5_clamp) else $error("over-range count not clamped"); // R5

  property p_rd_answer;
    @(posedge clk) disable iff (rst)
      rd_take |=> reg_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered"); // R8

  // A write must never be answered as if it were a read
  property p_rd_quiet;
    @(posedge clk) disable iff (rst)
      !rd_take |=> !reg_rvalid;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("answer without read"); // R3

  property p_rdata_hold;
    @(posedge clk) disable iff (rst)
      !rd_take |=> $stable(reg_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved"); // R3

endmodule : alr_result_regs

// [hw/alr_pkg.sv]
/*
  Package for the ambient light result registers: register offsets, field
  layout, reset values and refresh timing.
  Assumes a 50 MHz system clock shared with the converter and the serial slave.
*/
package alr_pkg;

  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned REFRESH_MS    = 80;
  localparam int unsigned REFRESH_CYC   = CLK_HZ / 1000 * REFRESH_MS;

  localparam int unsigned COUNT_W       = 13;
  localparam logic [12:0] COUNT_MAX     = 13'h1F40;
  localparam logic [12:0] COUNT_RESET   = 13'h0000;

  localparam logic [7:0]  ADDR_FIRST_LOW   = 8'h40;
  localparam logic [7:0]  ADDR_FIRST_HIGH  = 8'h41;
  localparam logic [7:0]  ADDR_SECOND_LOW  = 8'h42;
  localparam logic [7:0]  ADDR_SECOND_HIGH = 8'h43;

  localparam int unsigned UPPER_LSB     = 8;
  localparam int unsigned UPPER_W       = 5;
  localparam logic [7:0]  RDATA_RESET   = 8'h00;

  typedef struct packed {
    logic        valid;
    logic [12:0] count;
  } alr_conv_s;

endpackage : alr_pkg

// [verif/alr_host_model.sv]
/* Host model: one- or two-cycle read strobes and one-cycle write strobes on the result port.
   Assumes the bench calls acc or pair_rd and nothing else drives the strobes. */
`timescale 1ns/1ps
module alr_host_model (
  input  wire logic       clk,
  output logic      [7:0] reg_addr,
  output logic            reg_rd,
  output logic            reg_wr
);
  initial begin
    reg_addr = 8'h00;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
  end
  // Address is scrambled after use so stale values are never read
  task automatic acc(input logic [7:0] a, input logic w);
    @(negedge clk);
    reg_addr = a;
    reg_rd = !w;
    reg_wr = w;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_addr = ~a;
  endtask : acc
  // Lower then upper in back-to-back cycles, strobe held high between them
  task automatic pair_rd(input logic [7:0] a);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_addr = a + 8'h01;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
  endtask : pair_rd
endmodule : alr_host_model

// [verif/alr_result_regs_tb_top.sv]
/* Bench for the light result registers: reads checked through a queue.
   Assumes the refresh period is shortened to 16 cycles. */
`timescale 1ns/1ps
module alr_result_regs_tb_top;
  import alr_pkg::*;
  localparam int unsigned RC = 16;
  logic       clk = 0;
  logic       rst = 1;
  logic [1:0] sensor_en = '0;
  alr_conv_s  conv_first = '0;
  alr_conv_s  conv_second = '0;
  logic [7:0] reg_addr;
  logic [7:0] reg_rdata;
  logic       reg_rd;
  logic       reg_wr;
  logic       reg_rvalid;
  logic [7:0] exp_q[$];
  logic [12:0] c1;
  int miscompares = 0;
  int comparisons = 0;
  int cyc = 0;
  always #10 clk = ~clk;
  alr_host_model alr_host_model_i (.clk(clk), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_wr(reg_wr));
  alr_result_regs #(.REFRESH_CYCLES(RC)) alr_result_regs_i (.clk(clk), .rst(rst),
    .sensor_en(sensor_en), .conv_first(conv_first), .conv_second(conv_second),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid));
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic end_sim;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    alr_host_model_i.acc(a, 1'b0);
  endtask : rd
  // Lower first, so the upper byte comes from the same measurement
  task automatic pair(input logic [7:0] a, input logic [12:0] c);
    exp_q.push_back(c[7:0]);
    exp_q.push_back({3'b000, c[12:8]});
    alr_host_model_i.pair_rd(a);
  endtask : pair
  function automatic logic [12:0] clp(input logic [12:0] c);
    return (c > COUNT_MAX) ? COUNT_MAX : c;
  endfunction : clp
  always @(negedge clk) begin
    if (reg_rvalid === 1'b1 && exp_q.size() == 0) chk("rvalid", 8'h01, 8'h00);
    else if (reg_rvalid === 1'b1) chk("rdata", reg_rdata, exp_q.pop_front());
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      miscompares++;
      end_sim();
    end
  end
  initial begin
    void'($urandom(98));
    repeat (2) @(negedge clk);
    rst = 0;
    pair(ADDR_FIRST_LOW, 13'h0000);
    pair(ADDR_SECOND_LOW, 13'h0000);
    rd(8'h44, 8'h00);
    $display("test reset done");
    c1 = 13'($urandom_range(8191));
    conv_first = '{1'b1, c1};
    conv_second = '{1'b1, 13'h1FFF};
    sensor_en = 2'b11;
    repeat (2 * RC) @(negedge clk);
    pair(ADDR_FIRST_LOW, clp(c1));
    pair(ADDR_SECOND_LOW, COUNT_MAX);
    alr_host_model_i.acc(ADDR_FIRST_LOW, 1'b1);
    pair(ADDR_FIRST_LOW, clp(c1));
    $display("test refresh done");
    sensor_en = 2'b10;
    conv_first.count = 13'h0123;
    repeat (2 * RC) @(negedge clk);
    pair(ADDR_FIRST_LOW, clp(c1));
    sensor_en = 2'b11;
    repeat (2 * RC) @(negedge clk);
    pair(ADDR_FIRST_LOW, 13'h0123);
    $display("test enable done");
    conv_first = '{1'b0, 13'h0456};
    repeat (2 * RC) @(negedge clk);
    pair(ADDR_FIRST_LOW, 13'h0123);
    $display("test valid done");
    rst = 1;
    repeat (2) @(negedge clk);
    rst = 0;
    pair(ADDR_FIRST_LOW, COUNT_RESET);
    pair(ADDR_SECOND_LOW, COUNT_RESET);
    $display("test mid reset done");
    repeat (2) @(negedge clk);
    chk("pending reads", 8'(exp_q.size()), 8'h00);
    end_sim();
  end
endmodule : alr_result_regs_tb_top
